// >>> obc_defs.vh
/*
 * constants of the option byte configuration decoder: register offsets,
 * option byte field positions, reset values and decode codes.
 * assumes inclusion by the design files of the decoder only.
 */
`ifndef OBC_DEFS_VH
`define OBC_DEFS_VH

// register byte offsets on the bus
`define OBC_OFS_OPT0      8'h00
`define OBC_OFS_OPT1      8'h04
`define OBC_OFS_STAT      8'h08
`define OBC_OFS_CMD       8'h0C
`define OBC_OFS_ERR       8'h10
`define OBC_OFS_WDAT      8'h14

// option byte 0 fields
`define OBC_B0_RSV0_BIT   7
`define OBC_B0_RSV1_BIT   6
`define OBC_B0_CLK_HI     5
`define OBC_B0_CLK_LO     4
`define OBC_B0_SZ_HI      3
`define OBC_B0_SZ_LO      2
`define OBC_B0_RDP_BIT    1
`define OBC_B0_WRP_BIT    0

// option byte 1 field
`define OBC_B1_OSC_BIT    4

// default and erased values
`define OBC_OPT0_RESET    8'h74
`define OBC_OPT1_RESET    8'hEF
`define OBC_ERASED_BYTE   8'hFF

// clock source field codes
`define OBC_CS_RESONATOR  2'h0
`define OBC_CS_PORTB4     2'h1
`define OBC_CS_RESERVED   2'h2
`define OBC_CS_PORTC0     2'h3

// decoded clock selection
`define OBC_CK_RC         3'h0
`define OBC_CK_RESONATOR  3'h1
`define OBC_CK_EXT_PORTB4 3'h2
`define OBC_CK_EXT_PORTC0 3'h3
`define OBC_CK_INVALID    3'h4

// sector 0 sizes in bytes
`define OBC_SZ_0K5        13'h0200
`define OBC_SZ_1K         13'h0400
`define OBC_SZ_2K         13'h0800
`define OBC_SZ_4K         13'h1000

// command register bits
`define OBC_CMD_OPT_PROG  0
`define OBC_CMD_OPT_ERASE 1
`define OBC_CMD_MEM_PROG  2
`define OBC_CMD_MEM_ERASE 3

// error register bits
`define OBC_ERR_WRP       0
`define OBC_ERR_MODE      1
`define OBC_ERR_RSV       2
`define OBC_ERR_BUSY      3

`endif

// >>> obc_decode.v
/*
 * combinational decode of the two latched option bytes into clock,
 * sector and protection settings.
 * assumes the bytes are held stable by the caller.
 */
`timescale 1ns/1ns
`include "obc_defs.vh"

module obc_decode (
    input  wire [7:0]  opt0,
    input  wire [7:0]  opt1,
    output reg  [2:0]  clk_sel,
    output wire        port_c_en,
    output wire        rc_on,
    output wire        delay256,
    output wire [12:0] sector_bytes,
    output wire        rdp,
    output wire        wrp,
    output wire        rsv_ok
);
    wire [1:0] cs;
    wire [1:0] szf;

    function [12:0] sz_bytes;
        input [1:0] f;
        begin
            case (f)
                2'h0:    sz_bytes = `OBC_SZ_0K5;
                2'h1:    sz_bytes = `OBC_SZ_1K;
                2'h2:    sz_bytes = `OBC_SZ_2K;
                default: sz_bytes = `OBC_SZ_4K;
            endcase
        end
    endfunction

    assign cs  = opt0[`OBC_B0_CLK_HI:`OBC_B0_CLK_LO];
    assign szf = opt0[`OBC_B0_SZ_HI:`OBC_B0_SZ_LO];
    // osc bit 0 keeps rc running
    assign rc_on = ~opt1[`OBC_B1_OSC_BIT];
    // default field with rc gives long start-up
    assign delay256 = rc_on & (cs == `OBC_CS_PORTC0);
    assign port_c_en = rc_on | (cs != `OBC_CS_RESONATOR);
    assign sector_bytes = sz_bytes(szf);
    assign rdp = opt0[`OBC_B0_RDP_BIT];
    assign wrp = opt0[`OBC_B0_WRP_BIT];
    assign rsv_ok = ~opt0[`OBC_B0_RSV0_BIT] & opt0[`OBC_B0_RSV1_BIT];

    always @* begin
        if (rc_on) begin
            clk_sel = `OBC_CK_RC;
        end else begin
            case (cs)
                `OBC_CS_RESONATOR: clk_sel = `OBC_CK_RESONATOR;
                `OBC_CS_PORTB4:    clk_sel = `OBC_CK_EXT_PORTB4;
                `OBC_CS_PORTC0:    clk_sel = `OBC_CK_EXT_PORTC0;
                default:           clk_sel = `OBC_CK_INVALID;
            endcase
        end
    end
endmodule

// >>> obc_erase_seq.v
/*
 * erase sequencer: memory erase, and option erase that wipes the whole
 * memory first when read-out protection is on.
 * assumes mem_done pulses once the memory erase has finished.
 */
`timescale 1ns/1ns
`include "obc_defs.vh"

module obc_erase_seq (
    input  wire hclk,
    input  wire hresetn,
    input  wire start_mem,
    input  wire start_opt,
    input  wire rdp,
    input  wire mem_done,
    output wire mem_erase,
    output wire opt_erase,
    output wire busy
);
    localparam [1:0] S_IDLE = 2'h0;
    localparam [1:0] S_MEM  = 2'h1;
    localparam [1:0] S_WAIT = 2'h2;
    localparam [1:0] S_OPT  = 2'h3;

    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg       then_opt_r;
    reg       then_opt_nxt;
    reg       mem_erase_r;
    reg       opt_erase_r;

    always @* begin
        state_nxt = state_r;
        then_opt_nxt = then_opt_r;
        case (state_r)
            S_IDLE: begin
                if (start_opt) begin
                    then_opt_nxt = 1'b1;
                    // protected bytes wipe the memory first
                    state_nxt = rdp ? S_MEM : S_OPT;
                end else if (start_mem) begin
                    then_opt_nxt = 1'b0;
                    state_nxt = S_MEM;
                end
            end
            S_MEM:  state_nxt = S_WAIT;
            S_WAIT: begin
                if (mem_done) begin
                    state_nxt = then_opt_r ? S_OPT : S_IDLE;
                end
            end
            S_OPT:   state_nxt = S_IDLE;
            default: state_nxt = S_IDLE;
        endcase
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r <= S_IDLE;
            then_opt_r <= 1'b0;
            mem_erase_r <= 1'b0;
            opt_erase_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            then_opt_r <= then_opt_nxt;
            mem_erase_r <= (state_nxt == S_MEM);
            opt_erase_r <= (state_nxt == S_OPT);
        end
    end

    assign mem_erase = mem_erase_r;
    assign opt_erase = opt_erase_r;
    assign busy = (state_r != S_IDLE);
endmodule

// >>> obc_top.v
/*
 * option byte configuration decoder: latches the two option bytes at
 * reset release, drives clock, sector and protection settings, and
 * gates programming commands arriving over an ahb-lite slave.
 * assumes the option bytes and prog_mode are synchronous to hclk.
 */
// The implementer's own choices: register access over AHB-Lite and the address map.
// Contract
// - with rc off, clock field picks resonator, port b or c input
// - sector 0 size from bits 3:2: 0.5k, 1k, 2k, 4k
// - read-out protection blocks memory extraction and flash writes
// - erasing protected option bytes erases whole memory first
// - write protection forever refuses memory and bit erase or program
// - erased program memory reads all ones
// - byte 1 bit 4: 0 rc oscillator on, 1 off
`timescale 1ns/1ns
`include "obc_defs.vh"

module obc_top (
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output wire        hreadyout,
    output wire        hresp,
    output wire [31:0] hrdata,
    input  wire [7:0]  opt_byte0,
    input  wire [7:0]  opt_byte1,
    input  wire        prog_mode,
    input  wire        mem_erase_done,
    output wire [2:0]  clk_sel,
    output wire        port_c_en,
    output wire        rc_osc_en,
    output wire        startup_delay256,
    output wire [12:0] sector0_bytes,
    output wire        readout_block,
    output wire        flash_write_block,
    output wire        mem_prog,
    output wire        mem_erase,
    output wire [7:0]  mem_fill_byte,
    output wire        opt_prog,
    output wire        opt_erase,
    output wire [15:0] opt_wr_data
);
    reg        loaded_r;
    reg [7:0]  opt0_r;
    reg [7:0]  opt1_r;
    reg [2:0]  clk_sel_r;
    reg        port_c_en_r;
    reg        rc_osc_en_r;
    reg        delay256_r;
    reg [12:0] sector_r;
    reg        rd_block_r;
    reg        wr_block_r;
    reg        mem_prog_r;
    reg        opt_prog_r;
    reg [15:0] wdat_r;
    reg [15:0] opt_wr_r;
    reg [3:0]  err_r;
    reg [3:0]  err_nxt;
    reg [3:0]  err_set;
    reg [31:0] hrdata_r;
    reg [31:0] rdata_nxt;
    reg        wr_pend_r;
    reg [7:0]  waddr_r;

    wire [2:0]  dec_clk;
    wire        dec_pc;
    wire        dec_rc;
    wire        dec_d256;
    wire [12:0] dec_sec;
    wire        dec_rdp;
    wire        dec_wrp;
    wire        dec_rsv;
    wire        seq_busy;
    wire        addr_ph;
    wire        cmd_wr;
    wire [3:0]  cmd;
    wire        go_opt_prog;
    wire        go_opt_erase;
    wire        go_mem_prog;
    wire        go_mem_erase;
    wire        wdat_rsv_ok;

    obc_decode u_dec (
        .opt0         (opt0_r),
        .opt1         (opt1_r),
        .clk_sel      (dec_clk),
        .port_c_en    (dec_pc),
        .rc_on        (dec_rc),
        .delay256     (dec_d256),
        .sector_bytes (dec_sec),
        .rdp          (dec_rdp),
        .wrp          (dec_wrp),
        .rsv_ok       (dec_rsv)
    );

    // bytes sampled once after reset release, then frozen
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            loaded_r <= 1'b0;
            opt0_r <= `OBC_OPT0_RESET;
            opt1_r <= `OBC_OPT1_RESET;
        end else if (!loaded_r) begin
            loaded_r <= 1'b1;
            opt0_r <= opt_byte0;
            opt1_r <= opt_byte1;
        end
    end

    // registered decoded settings
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clk_sel_r <= `OBC_CK_RC;
            port_c_en_r <= 1'b1;
            rc_osc_en_r <= 1'b1;
            delay256_r <= 1'b1;
            sector_r <= `OBC_SZ_1K;
            rd_block_r <= 1'b1;
            wr_block_r <= 1'b1;
        end else begin
            clk_sel_r <= dec_clk;
            port_c_en_r <= dec_pc;
            rc_osc_en_r <= dec_rc;
            delay256_r <= dec_d256;
            sector_r <= dec_sec;
            // blocks held until bytes are known
            rd_block_r <= ~loaded_r | dec_rdp;
            wr_block_r <= ~loaded_r | dec_rdp | dec_wrp;
        end
    end

    // ahb-lite slave, zero wait states
    assign addr_ph = hsel & htrans[1] & hready;

    always @* begin
        rdata_nxt = 32'h0000_0000;
        case (haddr[7:0])
            `OBC_OFS_OPT0: rdata_nxt[7:0] = prog_mode ? opt0_r : 8'h00;
            `OBC_OFS_OPT1: rdata_nxt[7:0] = prog_mode ? opt1_r : 8'h00;
            `OBC_OFS_STAT: rdata_nxt[12:0] = {loaded_r, seq_busy, prog_mode,
                                              dec_rsv, dec_wrp, dec_rdp,
                                              opt0_r[`OBC_B0_SZ_HI:
                                                     `OBC_B0_SZ_LO],
                                              dec_d256, dec_rc, dec_clk};
            `OBC_OFS_ERR:  rdata_nxt[3:0] = err_r;
            `OBC_OFS_WDAT: rdata_nxt[15:0] = wdat_r;
            default:       rdata_nxt = 32'h0000_0000;
        endcase
        if (haddr[31:8] != 24'h00_0000) begin
            rdata_nxt = 32'h0000_0000;
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            waddr_r <= 8'h00;
            hrdata_r <= 32'h0000_0000;
        end else begin
            wr_pend_r <= addr_ph & hwrite & (haddr[31:8] == 24'h00_0000);
            if (addr_ph) begin
                waddr_r <= haddr[7:0];
            end
            if (addr_ph & ~hwrite) begin
                hrdata_r <= rdata_nxt;
            end
        end
    end

    assign cmd_wr = wr_pend_r & (waddr_r == `OBC_OFS_CMD);
    assign cmd = hwdata[3:0];
    assign wdat_rsv_ok = ~wdat_r[`OBC_B0_RSV0_BIT] &
                         wdat_r[`OBC_B0_RSV1_BIT];

    // command gating in programming mode only
    assign go_opt_prog = cmd_wr & cmd[`OBC_CMD_OPT_PROG] & prog_mode &
                         ~seq_busy & ~dec_wrp & wdat_rsv_ok;
    assign go_opt_erase = cmd_wr & cmd[`OBC_CMD_OPT_ERASE] & prog_mode &
                          ~seq_busy & ~dec_wrp;
    assign go_mem_prog = cmd_wr & cmd[`OBC_CMD_MEM_PROG] & prog_mode &
                         ~seq_busy & ~dec_wrp & ~dec_rdp;
    assign go_mem_erase = cmd_wr & cmd[`OBC_CMD_MEM_ERASE] & prog_mode &
                          ~seq_busy & ~dec_wrp & ~go_opt_erase;

    always @* begin
        err_set = 4'h0;
        if (cmd_wr & (cmd != 4'h0)) begin
            err_set[`OBC_ERR_MODE] = ~prog_mode;
            err_set[`OBC_ERR_BUSY] = prog_mode & seq_busy;
            err_set[`OBC_ERR_WRP] = prog_mode & ~seq_busy &
                                    (dec_wrp | (dec_rdp &
                                     cmd[`OBC_CMD_MEM_PROG]));
            err_set[`OBC_ERR_RSV] = prog_mode & ~seq_busy &
                                    cmd[`OBC_CMD_OPT_PROG] &
                                    ~wdat_rsv_ok;
        end
        err_nxt = err_r;
        if (wr_pend_r & (waddr_r == `OBC_OFS_ERR)) begin
            err_nxt = err_r & ~hwdata[3:0];
        end
        err_nxt = err_nxt | err_set;
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            err_r <= 4'h0;
            wdat_r <= {`OBC_OPT1_RESET, `OBC_OPT0_RESET};
            mem_prog_r <= 1'b0;
            opt_prog_r <= 1'b0;
            opt_wr_r <= {`OBC_OPT1_RESET, `OBC_OPT0_RESET};
        end else begin
            err_r <= err_nxt;
            if (wr_pend_r & (waddr_r == `OBC_OFS_WDAT) & prog_mode) begin
                wdat_r <= hwdata[15:0];
            end
            mem_prog_r <= go_mem_prog;
            opt_prog_r <= go_opt_prog;
            if (go_opt_prog) begin
                opt_wr_r <= wdat_r;
            end
        end
    end

    obc_erase_seq u_seq (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .start_mem (go_mem_erase),
        .start_opt (go_opt_erase),
        .rdp       (dec_rdp),
        .mem_done  (mem_erase_done),
        .mem_erase (mem_erase),
        .opt_erase (opt_erase),
        .busy      (seq_busy)
    );

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_r;
    assign clk_sel = clk_sel_r;
    assign port_c_en = port_c_en_r;
    assign rc_osc_en = rc_osc_en_r;
    assign startup_delay256 = delay256_r;
    assign sector0_bytes = sector_r;
    assign readout_block = rd_block_r;
    assign flash_write_block = wr_block_r;
    assign mem_prog = mem_prog_r;
    assign mem_fill_byte = `OBC_ERASED_BYTE;
    assign opt_prog = opt_prog_r;
    assign opt_wr_data = opt_wr_r;
endmodule

// >>> obc_chk_sva.sv
/* checker of the decoded settings against the option bytes latched at
   reset release. assumes the cell values are stable across release. */
`timescale 1ns/1ns
module obc_chk (
    input wire        hclk,
    input wire        hresetn,
    input wire [7:0]  opt_byte0,
    input wire [7:0]  opt_byte1,
    input wire [2:0]  clk_sel,
    input wire        rc_osc_en,
    input wire [12:0] sector0_bytes,
    input wire        readout_block,
    input wire        flash_write_block,
    input wire        mem_prog,
    input wire        mem_erase,
    input wire [7:0]  mem_fill_byte,
    input wire        opt_prog,
    input wire        opt_erase,
    input wire        mem_erase_done
);
    reg  [1:0] cnt_r;
    reg  [7:0] lat0_r;
    reg  [7:0] lat1_r;
    wire [2:0] clk_exp;
    assign clk_exp = !lat1_r[4] ? 3'h0 : lat0_r[5:4] == 2'h0 ? 3'h1 :
                     lat0_r[5:4] == 2'h1 ? 3'h2 :
                     lat0_r[5:4] == 2'h3 ? 3'h3 : 3'h4;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_r <= 2'h0;
            lat0_r <= 8'h00;
            lat1_r <= 8'h00;
        end else begin
            if (cnt_r == 2'h0) begin
                lat0_r <= opt_byte0;
                lat1_r <= opt_byte1;
            end
            if (cnt_r != 2'h3) cnt_r <= cnt_r + 2'h1;
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_fill_erased: assert property (mem_fill_byte == 8'hFF)
        else $error("fill byte not all ones");
    a_settings_held: assert property (cnt_r == 2'h3 |->
        $stable(clk_sel) && $stable(sector0_bytes) && $stable(rc_osc_en))
        else $error("settings moved after latch");
    a_sector_size: assert property (cnt_r[1] |->
        sector0_bytes == (13'h0200 << lat0_r[3:2]))
        else $error("sector size wrong");
    a_clock_pick: assert property (cnt_r[1] |-> clk_sel == clk_exp)
        else $error("clock selection wrong");
    a_rc_select: assert property (cnt_r[1] |-> rc_osc_en == !lat1_r[4])
        else $error("rc enable wrong");
    a_readout_gate: assert property (cnt_r[1] |->
        readout_block == lat0_r[1] && (!lat0_r[1] || flash_write_block))
        else $error("readout gate wrong");
    a_write_lock: assert property (cnt_r[1] && lat0_r[0] |->
        flash_write_block && !(mem_prog || mem_erase || opt_prog || opt_erase))
        else $error("write lock leaked");
    a_erase_order: assert property (opt_erase && lat0_r[1] |->
        $past(mem_erase_done)) else $error("option erase before memory");
    c_opt_prog: cover property (opt_prog);
    c_mem_prog: cover property (mem_prog);
    c_rdp_erase: cover property (mem_erase ##[1:100] opt_erase);
endmodule

bind obc_top obc_chk obc_chk_inst (.hclk(hclk), .hresetn(hresetn),
    .opt_byte0(opt_byte0), .opt_byte1(opt_byte1), .clk_sel(clk_sel),
    .rc_osc_en(rc_osc_en), .sector0_bytes(sector0_bytes),
    .readout_block(readout_block), .flash_write_block(flash_write_block),
    .mem_prog(mem_prog), .mem_erase(mem_erase),
    .mem_fill_byte(mem_fill_byte), .opt_prog(opt_prog),
    .opt_erase(opt_erase), .mem_erase_done(mem_erase_done));

// >>> obc_prog_tool.sv
/* programming tool and cell model: holds the option bytes, writes them
   on granted program or erase, answers memory erase after done_dly. */
`timescale 1ns/1ns
module obc_prog_tool (
    input  wire        hclk,
    input  wire        load,
    input  wire [15:0] load_val,
    input  wire        opt_prog,
    input  wire        opt_erase,
    input  wire [15:0] opt_wr_data,
    input  wire        mem_erase,
    input  wire [7:0]  done_dly,
    output reg  [7:0]  opt_byte0,
    output reg  [7:0]  opt_byte1,
    output reg         mem_erase_done
);
    reg [7:0] wait_r;
    initial begin
        opt_byte0 = 8'h74;
        opt_byte1 = 8'hEF;
        mem_erase_done = 1'b0;
        wait_r = 8'h00;
    end
    always @(posedge hclk) begin
        mem_erase_done <= 1'b0;
        if (load) {opt_byte1, opt_byte0} <= load_val;
        else if (opt_prog) {opt_byte1, opt_byte0} <= opt_wr_data;
        else if (opt_erase) {opt_byte1, opt_byte0} <= 16'hFFFF;
        if (mem_erase) wait_r <= done_dly;
        else if (wait_r == 8'h01) begin
            mem_erase_done <= 1'b1;
            wait_r <= 8'h00;
        end else if (wait_r != 8'h00) wait_r <= wait_r - 8'h01;
    end
endmodule

// >>> tb_obc_top.sv
/* self-checking bench of the option byte decoder over ahb-lite.
   assumes a single slave, so hready follows hreadyout. */
`timescale 1ns/1ns
module tb_obc_top;
    reg         hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    reg  [31:0] haddr = 32'h0, hwdata = 32'h0;
    reg  [1:0]  htrans = 2'h0;
    reg  [2:0]  hsize = 3'h2;
    reg         prog_mode = 1'b0, load = 1'b0;
    reg  [15:0] load_val = 16'hEF74;
    reg  [7:0]  done_dly = 8'h14, b0, b1;
    wire        hready, hresp, port_c_en, rc_osc_en, startup_delay256;
    wire        readout_block, flash_write_block, mem_prog, mem_erase;
    wire        opt_prog, opt_erase, mem_erase_done;
    wire [31:0] hrdata;
    wire [7:0]  opt_byte0, opt_byte1, mem_fill_byte;
    wire [2:0]  clk_sel;
    wire [12:0] sector0_bytes;
    wire [15:0] opt_wr_data;
    reg  [31:0] rd;
    int         n_fail, checked, n_op, n_oe, n_me, n_mp, i;
    time        t_me, t_oe;
    reg  [15:0] tbl [0:5] = '{16'hFF40, 16'hFF55, 16'hFF7A, 16'hFF67,
                              16'hEF74, 16'hEF7C};

    obc_top obc_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hreadyout(hready),
        .hresp(hresp), .hrdata(hrdata), .opt_byte0(opt_byte0),
        .opt_byte1(opt_byte1), .prog_mode(prog_mode),
        .mem_erase_done(mem_erase_done), .clk_sel(clk_sel),
        .port_c_en(port_c_en), .rc_osc_en(rc_osc_en),
        .startup_delay256(startup_delay256), .sector0_bytes(sector0_bytes),
        .readout_block(readout_block), .flash_write_block(flash_write_block),
        .mem_prog(mem_prog), .mem_erase(mem_erase),
        .mem_fill_byte(mem_fill_byte), .opt_prog(opt_prog),
        .opt_erase(opt_erase), .opt_wr_data(opt_wr_data));
    obc_prog_tool obc_prog_tool_inst (.hclk(hclk), .load(load),
        .load_val(load_val), .opt_prog(opt_prog), .opt_erase(opt_erase),
        .opt_wr_data(opt_wr_data), .mem_erase(mem_erase),
        .done_dly(done_dly), .opt_byte0(opt_byte0),
        .opt_byte1(opt_byte1), .mem_erase_done(mem_erase_done));

    always #5 hclk = ~hclk;
    always @(posedge hclk) begin
        if (opt_prog === 1'b1) n_op++;
        if (mem_prog === 1'b1) n_mp++;
        if (mem_erase === 1'b1) begin n_me++; t_me = $time; end
        if (opt_erase === 1'b1) begin n_oe++; t_oe = $time; end
    end

    function [2:0] exp_clk(input [7:0] c0, input [7:0] c1);
        if (!c1[4]) exp_clk = 3'h0;
        else case (c0[5:4])
            2'h0: exp_clk = 3'h1;
            2'h1: exp_clk = 3'h2;
            2'h3: exp_clk = 3'h3;
            default: exp_clk = 3'h4;
        endcase
    endfunction
    task chk(input string nm, input [31:0] exp, input [31:0] got);
        checked++;
        if (got !== exp) begin
            $display("Error %0s expected %h seen %h", nm, exp, got);
            n_fail++;
        end
    endtask
    task ahb(input w, input [7:0] a, input [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1; haddr <= {24'h0, a}; htrans <= 2'h2; hwrite <= w;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        htrans <= 2'h0; hwdata <= d;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask
    task rst(input [7:0] c0, input [7:0] c1);
        @(posedge hclk);
        load <= 1'b1; load_val <= {c1, c0}; hresetn <= 1'b0;
        @(posedge hclk);
        load <= 1'b0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (3) @(posedge hclk);
        n_op = 0; n_oe = 0; n_me = 0; n_mp = 0;
    endtask
    task dchk(input [7:0] c0, input [7:0] c1);
        chk("clk_sel", 32'(exp_clk(c0, c1)), 32'(clk_sel));
        chk("rc_osc_en", 32'(!c1[4]), 32'(rc_osc_en));
        chk("port_c", 32'(!c1[4] | (c0[5:4] != 2'h0)), 32'(port_c_en));
        chk("dly256", 32'(!c1[4] & (c0[5:4] == 2'h3)), 32'(startup_delay256));
        chk("sector0", 32'(13'h0200 << c0[3:2]), 32'(sector0_bytes));
        chk("readout", 32'(c0[1]), 32'(readout_block));
        chk("wr_block", 32'(c0[1] | c0[0]), 32'(flash_write_block));
        chk("fill", 32'hFF, 32'(mem_fill_byte));
    endtask
    task end_sim;
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        #100000;
        n_fail++;
        end_sim;
    end
    initial begin
        n_fail = 0; checked = 0;
        rd = $urandom(32'h781F3CF4);
        for (i = 0; i < 12; i++) begin
            {b1, b0} = i < 6 ? tbl[i] : {8'($urandom), 2'h1, 6'($urandom)};
            if (!b1[4]) b0[5:4] = 2'h3;
            rst(b0, b1);
            dchk(b0, b1);
            prog_mode <= 1'b1;
            ahb(1'b0, 8'h08, 32'h0);
            chk("stat_clk", 32'(exp_clk(b0, b1)), 32'(rd[2:0]));
            ahb(1'b0, 8'h00, 32'h0);
            chk("opt0", 32'(b0), rd);
            prog_mode <= 1'b0;
            load <= 1'b1; load_val <= ~{b1, b0};
            @(posedge hclk);
            load <= 1'b0;
            repeat (3) @(posedge hclk);
            dchk(b0, b1);
        end
        $display("test decode done");
        rst(8'h74, 8'hEF);
        prog_mode <= 1'b1;
        ahb(1'b1, 8'h14, 32'h0000FF5C);
        ahb(1'b1, 8'h0C, 32'h1);
        ahb(1'b1, 8'h0C, 32'h4);
        repeat (3) @(posedge hclk);
        chk("opt_prog", 32'h1, 32'(n_op));
        chk("mem_prog", 32'h1, 32'(n_mp));
        chk("wr_data", 32'hFF5C, 32'(opt_wr_data));
        chk("clk_kept", 32'h0, 32'(clk_sel));
        ahb(1'b1, 8'h14, 32'h0000FFB4);
        ahb(1'b1, 8'h0C, 32'h1);
        ahb(1'b0, 8'h10, 32'h0);
        chk("err_rsv", 32'h1, 32'(rd[2]));
        prog_mode <= 1'b0;
        ahb(1'b1, 8'h0C, 32'h1);
        ahb(1'b0, 8'h10, 32'h0);
        chk("err_mode", 32'h1, 32'(rd[1]));
        ahb(1'b0, 8'h00, 32'h0);
        chk("opt0_run", 32'h0, rd);
        ahb(1'b0, 8'h20, 32'h0);
        chk("unmapped", 32'h0, rd);
        chk("hresp", 32'h0, 32'(hresp));
        chk("opt_prog2", 32'h1, 32'(n_op));
        rst(opt_byte0, opt_byte1);
        dchk(8'h5C, 8'hFF);
        $display("test program done");
        for (i = 0; i < 2; i++) begin
            rst(8'h76, 8'hEF);
            done_dly <= i == 0 ? 8'h14 : 8'h01;
            prog_mode <= 1'b1;
            ahb(1'b1, 8'h0C, 32'h4);
            ahb(1'b1, 8'h0C, 32'h2);
            repeat (40) @(posedge hclk);
            chk("rdp_mprog", 32'h0, 32'(n_mp));
            chk("mem_erase", 32'h1, 32'(n_me));
            chk("opt_erase", 32'h1, 32'(n_oe));
            chk("erase_ord", 32'h1, 32'(t_oe > t_me));
        end
        $display("test readout erase done");
        rst(8'h75, 8'hEF);
        prog_mode <= 1'b1;
        ahb(1'b1, 8'h14, 32'h0000EF74);
        ahb(1'b1, 8'h0C, 32'hF);
        repeat (40) @(posedge hclk);
        chk("wrp_pulses", 32'h0, 32'(n_op + n_oe + n_me + n_mp));
        ahb(1'b0, 8'h10, 32'h0);
        chk("err_wrp", 32'h1, 32'(rd[0]));
        $display("test write protect done");
        end_sim;
    end
endmodule
